/* logic/homing_pkg.sv */
// Constants and types shared by the homing sequencer.
// Assumes a 125 MHz core clock and a word-indexed register port.
package homing_pkg;
   // ************************************************
   // Register indices on the plain register port
   // ************************************************
   localparam logic [3:0] MODE_IDX = 4'h0;
   localparam logic [3:0] DIR_IDX = 4'h1;
   localparam logic [3:0] COORD_IDX = 4'h2;
   localparam logic [3:0] OFFSET_IDX = 4'h3;
   localparam logic [3:0] CAM_SPEED_IDX = 4'h4;
   localparam logic [3:0] CAM_MAX_IDX = 4'h5;
   localparam logic [3:0] ZM_SPEED_IDX = 4'h6;
   localparam logic [3:0] ZM_MAX_IDX = 4'h7;
   localparam logic [3:0] RP_SPEED_IDX = 4'h8;
   localparam logic [3:0] CTRL_IDX = 4'h9;
   localparam logic [3:0] STATUS_IDX = 4'hA;

   // ************************************************
   // Widths, field positions and reset values
   // ************************************************
   localparam int SPEED_W = 26;
   localparam int DIST_W = 31;
   localparam int CTRL_DONE_EN_BIT = 0;
   localparam logic [2:0] MODE_RST = 3'h1;
   localparam logic DIR_RST = 1'b0;
   localparam logic [31:0] COORD_RST = 32'h0000_0000;
   localparam logic [31:0] OFFSET_RST = 32'h0000_0000;
   localparam logic [SPEED_W-1:0] CAM_SPEED_RST = 26'h000_1388;
   localparam logic [SPEED_W-1:0] ZM_SPEED_RST = 26'h000_012C;
   localparam logic [SPEED_W-1:0] RP_SPEED_RST = 26'h000_012C;
   localparam logic [DIST_W-1:0] CAM_MAX_RST = 31'h7FFF_FC17;
   localparam logic [DIST_W-1:0] ZM_MAX_RST = 31'h0000_4E20;

   // ************************************************
   // Homing method codes and direction encoding
   // ************************************************
   localparam logic [2:0] MODE_REF_EDGE = 3'h0;
   localparam logic [2:0] MODE_CAM_ZERO = 3'h1;
   localparam logic [2:0] MODE_ZERO_ONLY = 3'h2;
   localparam logic [2:0] MODE_CCW_CAM = 3'h3;
   localparam logic [2:0] MODE_CW_CAM = 3'h4;
   localparam logic DIR_CW = 1'b0;
   localparam logic DIR_CCW = 1'b1;

   // ************************************************
   // Types
   // ************************************************
   typedef enum logic [6:0] {
      IDLE = 7'h01,
      CAM_SEARCH = 7'h02,
      CAM_STOP = 7'h04,
      ZM_SEARCH = 7'h08,
      RP_MOVE = 7'h10,
      DONE = 7'h20,
      FAULT = 7'h40
   } state_type;

   typedef struct packed {
      logic enable;
      logic dir_ccw;
      logic max_decel;
      logic [SPEED_W-1:0] speed;
   } motion_cmd_type;
endpackage

/* logic/homing_sequencer.sv */
// Homing sequencer for an incremental-encoder axis: zero-mark-only and
// counter-clockwise limit-cam methods, driving motion phases and done.
// Assumes the drive reports position and standstill synchronous to core_clk,
// and a register master that never needs a wait state.
//
// Notes on behaviour
// - A rising edge on the start request begins a homing run.
// - Start request dropping while homing stops the run at once.
// - Reaching the reference coordinate raises done, if done output enabled.
// - Zero-mark-only mode runs at zero-mark speed in configured direction.
// - Direction 0 is clockwise/positive, 1 counter-clockwise; resets to 0.
// - First zero mark starts the move toward offset at reference speed.
// - Reference coordinate is a signed 32-bit position, reset 0.
// - Reference offset is a signed 32-bit length, reset 0.
// - Cam search speed register, reset 5000.
// - Zero-mark search speed register, reset 300.
// - Reference point search speed register, reset 300.
// - Cam search travel is bounded by the cam maximum distance.
// - Zero-mark search travel is bounded by the zero-mark maximum distance.
// - Limit-cam mode first runs counter-clockwise at cam speed.
// - Falling ccw limit stops the axis with maximum deceleration.
// - After standstill run clockwise at zero-mark speed seeking zero mark.
// - Limit inputs do not stop travel while homing; restored afterwards.
// - Mode register selects one of five methods, reset 1; only codes 2 and 3 run, the rest fault.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none

module homing_sequencer (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic start_homing_request,
   input wire logic ccw_limit_input,
   input wire logic cw_limit_input,
   input wire logic zero_mark_pulse,
   input wire logic signed [31:0] axis_position,
   input wire logic axis_standstill,
   output homing_pkg::motion_cmd_type motion_cmd,
   output logic homing_done_output,
   output logic homing_error,
   output logic homing_busy,
   output logic cw_limit_stop,
   output logic ccw_limit_stop
);

   // ************************************************
   // Helper functions
   // ************************************************
   // Travel since a phase began, compared against its allowance
   function automatic logic over_distance(input logic signed [31:0] pos,
                                          input logic signed [31:0] start,
                                          input logic [homing_pkg::DIST_W-1:0] lim);
      logic signed [32:0] diff;
      logic [32:0] mag;
      diff = 33'(pos) - 33'(start);
      mag = diff[32] ? 33'(-diff) : 33'(diff);
      return mag > {2'b00, lim};
   endfunction

   // Target reached in the travel direction
   function automatic logic reached(input logic signed [31:0] pos,
                                    input logic signed [31:0] tgt,
                                    input logic ccw);
      return ccw ? (pos <= tgt) : (pos >= tgt);
   endfunction

   // ************************************************
   // Configuration registers
   // ************************************************
   logic [2:0] mode_reg;
   logic dir_reg;
   logic signed [31:0] coord_reg;
   logic signed [31:0] offset_reg;
   logic [homing_pkg::SPEED_W-1:0] cam_speed_reg, zm_speed_reg, rp_speed_reg;
   logic [homing_pkg::DIST_W-1:0] cam_max_reg, zm_max_reg;
   logic done_en_reg;

   homing_pkg::state_type state_reg, state_next;
   logic req_prev_reg, ccw_prev_reg, armed_reg;
   logic signed [31:0] start_pos_reg, target_reg;
   logic target_ccw_reg;

   // Write decode
   wire wr_mode = reg_wr && (reg_addr == homing_pkg::MODE_IDX);
   wire wr_dir = reg_wr && (reg_addr == homing_pkg::DIR_IDX);
   wire wr_coord = reg_wr && (reg_addr == homing_pkg::COORD_IDX);
   wire wr_offset = reg_wr && (reg_addr == homing_pkg::OFFSET_IDX);
   wire wr_cam_speed = reg_wr && (reg_addr == homing_pkg::CAM_SPEED_IDX);
   wire wr_cam_max = reg_wr && (reg_addr == homing_pkg::CAM_MAX_IDX);
   wire wr_zm_speed = reg_wr && (reg_addr == homing_pkg::ZM_SPEED_IDX);
   wire wr_zm_max = reg_wr && (reg_addr == homing_pkg::ZM_MAX_IDX);
   wire wr_rp_speed = reg_wr && (reg_addr == homing_pkg::RP_SPEED_IDX);
   wire wr_ctrl = reg_wr && (reg_addr == homing_pkg::CTRL_IDX);

   // Register writes; values outside documented ranges are stored as given
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         mode_reg <= homing_pkg::MODE_RST;
         dir_reg <= homing_pkg::DIR_RST;
         coord_reg <= homing_pkg::COORD_RST;
         offset_reg <= homing_pkg::OFFSET_RST;
         cam_speed_reg <= homing_pkg::CAM_SPEED_RST;
         zm_speed_reg <= homing_pkg::ZM_SPEED_RST;
         rp_speed_reg <= homing_pkg::RP_SPEED_RST;
         cam_max_reg <= homing_pkg::CAM_MAX_RST;
         zm_max_reg <= homing_pkg::ZM_MAX_RST;
         done_en_reg <= 1'b1;
      end else begin
         if (wr_mode) mode_reg <= reg_wdata[2:0];
         if (wr_dir) dir_reg <= reg_wdata[0];
         if (wr_coord) coord_reg <= reg_wdata;
         if (wr_offset) offset_reg <= reg_wdata;
         if (wr_cam_speed) cam_speed_reg <= reg_wdata[homing_pkg::SPEED_W-1:0];
         if (wr_cam_max) cam_max_reg <= reg_wdata[homing_pkg::DIST_W-1:0];
         if (wr_zm_speed) zm_speed_reg <= reg_wdata[homing_pkg::SPEED_W-1:0];
         if (wr_zm_max) zm_max_reg <= reg_wdata[homing_pkg::DIST_W-1:0];
         if (wr_rp_speed) rp_speed_reg <= reg_wdata[homing_pkg::SPEED_W-1:0];
         if (wr_ctrl) done_en_reg <= reg_wdata[homing_pkg::CTRL_DONE_EN_BIT];
      end
   end

   // Read mux; unmapped indices read zero
   logic [31:0] rd_mux;
   always_comb begin
      case (reg_addr)
         homing_pkg::MODE_IDX: rd_mux = {29'h0, mode_reg};
         homing_pkg::DIR_IDX: rd_mux = {31'h0, dir_reg};
         homing_pkg::COORD_IDX: rd_mux = coord_reg;
         homing_pkg::OFFSET_IDX: rd_mux = offset_reg;
         homing_pkg::CAM_SPEED_IDX: rd_mux = {6'h0, cam_speed_reg};
         homing_pkg::CAM_MAX_IDX: rd_mux = {1'b0, cam_max_reg};
         homing_pkg::ZM_SPEED_IDX: rd_mux = {6'h0, zm_speed_reg};
         homing_pkg::ZM_MAX_IDX: rd_mux = {1'b0, zm_max_reg};
         homing_pkg::RP_SPEED_IDX: rd_mux = {6'h0, rp_speed_reg};
         homing_pkg::CTRL_IDX: rd_mux = {31'h0, done_en_reg};
         homing_pkg::STATUS_IDX: rd_mux = {23'h0, state_reg, homing_error, homing_done_output};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (!reset_n) reg_rdata <= 32'h0000_0000;
      else reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
   end

   // ************************************************
   // Sequencer decode
   // ************************************************
   wire req_rise = start_homing_request && !req_prev_reg;
   wire ccw_fall = ccw_prev_reg && !ccw_limit_input;
   wire active = (state_reg != homing_pkg::IDLE) && (state_reg != homing_pkg::DONE)
                 && (state_reg != homing_pkg::FAULT);
   wire mode_ok = (mode_reg == homing_pkg::MODE_ZERO_ONLY)
                  || (mode_reg == homing_pkg::MODE_CCW_CAM);
   wire zm_seen = zero_mark_pulse && armed_reg;
   wire signed [31:0] zm_target = axis_position + offset_reg;
   wire rp_ccw = zm_target < axis_position;
   wire cam_over = over_distance(axis_position, start_pos_reg, cam_max_reg);
   wire zm_over = over_distance(axis_position, start_pos_reg, zm_max_reg);
   wire at_coord = reached(axis_position, target_reg, target_ccw_reg);

   // Next state; request low ends any run, including done and fault
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         homing_pkg::IDLE: begin
            if (req_rise && !mode_ok) state_next = homing_pkg::FAULT;
            else if (req_rise && mode_reg == homing_pkg::MODE_CCW_CAM)
               state_next = homing_pkg::CAM_SEARCH;
            else if (req_rise) state_next = homing_pkg::ZM_SEARCH;
         end
         homing_pkg::CAM_SEARCH: begin
            if (ccw_fall) state_next = homing_pkg::CAM_STOP;
            else if (cam_over) state_next = homing_pkg::FAULT;
         end
         homing_pkg::CAM_STOP:
            if (axis_standstill) state_next = homing_pkg::ZM_SEARCH;
         homing_pkg::ZM_SEARCH: begin
            if (zm_seen) state_next = homing_pkg::RP_MOVE;
            else if (zm_over) state_next = homing_pkg::FAULT;
         end
         homing_pkg::RP_MOVE:
            if (at_coord) state_next = homing_pkg::DONE;
         homing_pkg::DONE: state_next = homing_pkg::DONE;
         homing_pkg::FAULT: state_next = homing_pkg::FAULT;
         default: state_next = homing_pkg::IDLE;
      endcase
      if (!start_homing_request) state_next = homing_pkg::IDLE;
   end

   // Next motion command for the state being entered
   homing_pkg::motion_cmd_type cmd_next;
   logic zm_dir;
   always_comb begin
      zm_dir = (mode_reg == homing_pkg::MODE_CCW_CAM) ? homing_pkg::DIR_CW : dir_reg;
      cmd_next = '0;
      case (state_next)
         homing_pkg::CAM_SEARCH: cmd_next = {1'b1, homing_pkg::DIR_CCW, 1'b0, cam_speed_reg};
         homing_pkg::CAM_STOP: cmd_next = {1'b0, homing_pkg::DIR_CCW, 1'b1,
                                           {homing_pkg::SPEED_W{1'b0}}};
         homing_pkg::ZM_SEARCH: cmd_next = {1'b1, zm_dir, 1'b0, zm_speed_reg};
         homing_pkg::RP_MOVE: cmd_next = {1'b1, (state_reg == homing_pkg::RP_MOVE) ?
                                          target_ccw_reg : rp_ccw, 1'b0, rp_speed_reg};
         default: cmd_next = {1'b0, 1'b0, !start_homing_request && active,
                              {homing_pkg::SPEED_W{1'b0}}};
      endcase
   end

   // ************************************************
   // Sequencer state and outputs
   // ************************************************
   // Phase start position latched on entry so distance checks see true travel
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state_reg <= homing_pkg::IDLE;
         req_prev_reg <= 1'b0;
         ccw_prev_reg <= 1'b1;
         start_pos_reg <= 32'h0000_0000;
      end else begin
         state_reg <= state_next;
         req_prev_reg <= start_homing_request;
         ccw_prev_reg <= ccw_limit_input;
         if (state_next != state_reg) start_pos_reg <= axis_position;
      end
   end

   // In limit-cam mode zero marks count only once the ccw limit has come back high
   always_ff @(posedge core_clk) begin
      if (!reset_n) armed_reg <= 1'b0;
      else if (state_next == homing_pkg::ZM_SEARCH && state_reg != homing_pkg::ZM_SEARCH)
         armed_reg <= (mode_reg != homing_pkg::MODE_CCW_CAM) || ccw_limit_input;
      else if (ccw_limit_input) armed_reg <= 1'b1;
   end

   // Target is zero-mark position plus offset; the coordinate is what it means
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         target_reg <= 32'h0000_0000;
         target_ccw_reg <= 1'b0;
      end else if (state_reg == homing_pkg::ZM_SEARCH && zm_seen) begin
         target_reg <= zm_target;
         target_ccw_reg <= rp_ccw;
      end
   end

   // Registered outputs
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         motion_cmd <= '0;
         homing_done_output <= 1'b0;
         homing_error <= 1'b0;
         homing_busy <= 1'b0;
         cw_limit_stop <= 1'b0;
         ccw_limit_stop <= 1'b0;
      end else begin
         motion_cmd <= cmd_next;
         homing_done_output <= (state_next == homing_pkg::DONE) && done_en_reg;
         homing_error <= state_next == homing_pkg::FAULT;
         homing_busy <= state_next != homing_pkg::IDLE;
         cw_limit_stop <= !cw_limit_input && state_next == homing_pkg::IDLE;
         ccw_limit_stop <= !ccw_limit_input && state_next == homing_pkg::IDLE;
      end
   end

   // ************************************************
   // Assertions
   // ************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   start_edge_a: assert property (state_reg == homing_pkg::IDLE && req_rise && mode_ok
      |=> homing_busy && motion_cmd.enable) else $error("start edge not taken");
   req_drop_a: assert property ($fell(start_homing_request) |=> !homing_busy
      && !motion_cmd.enable && !homing_done_output) else $error("run not stopped");
   done_out_a: assert property (state_reg == homing_pkg::RP_MOVE && at_coord
      && start_homing_request |=> homing_done_output == done_en_reg)
      else $error("done not raised");
   zm_speed_a: assert property (state_reg == homing_pkg::IDLE && req_rise
      && mode_reg == homing_pkg::MODE_ZERO_ONLY |=> motion_cmd.speed == $past(zm_speed_reg)
      && motion_cmd.dir_ccw == $past(dir_reg)) else $error("zero search wrong");
   cam_dir_a: assert property (state_reg == homing_pkg::CAM_SEARCH |-> motion_cmd.dir_ccw
      && motion_cmd.speed == cam_speed_reg) else $error("cam search wrong");
   max_decel_a: assert property (state_reg == homing_pkg::CAM_SEARCH && ccw_fall
      && start_homing_request |=> motion_cmd.max_decel && !motion_cmd.enable)
      else $error("no stop on limit");
   reverse_a: assert property (state_reg == homing_pkg::CAM_STOP && axis_standstill
      && start_homing_request |=> motion_cmd.enable && !motion_cmd.dir_ccw)
      else $error("no clockwise reversal");
   over_abort_a: assert property (state_reg == homing_pkg::ZM_SEARCH && zm_over && !zm_seen
      && start_homing_request |=> homing_error && !motion_cmd.enable)
      else $error("overrun not aborted");
   limit_mask_a: assert property (homing_busy |-> !cw_limit_stop && !ccw_limit_stop)
      else $error("limit active while homing");
   done_hold_a: assert property (homing_done_output && start_homing_request
      |=> homing_done_output) else $error("done dropped early");

   zm_run_c: cover property (state_reg == homing_pkg::ZM_SEARCH ##1
      state_reg == homing_pkg::RP_MOVE);
   cam_run_c: cover property (state_reg == homing_pkg::CAM_STOP ##1
      state_reg == homing_pkg::ZM_SEARCH);
   done_c: cover property (homing_done_output ##1 !start_homing_request);
   fault_c: cover property (homing_error);

endmodule // homing_sequencer

`default_nettype wire

/* dv/axis_model.sv */
// Behavioural axis, encoder and cam that face the homing sequencer.
// Assumes the sequencer's core clock; the axis moves one length unit per step.
`timescale 1ns/100ps
`default_nettype none
module axis_model (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire homing_pkg::motion_cmd_type motion_cmd,
   input wire logic slow,
   input wire logic marks_on,
   input wire logic signed [31:0] cam_pos,
   output logic signed [31:0] axis_position,
   output logic axis_standstill,
   output logic zero_mark_pulse,
   output logic ccw_limit_input
);
   logic [1:0] brake_reg;
   logic half_reg;
   logic step;
   // Slow mode steps on every other cycle, which stretches each phase
   assign step = motion_cmd.enable && (!slow || half_reg);
   // Standstill lags the command, because a real axis needs time to brake
   assign axis_standstill = (brake_reg == 2'h3);
   // One mark every 64 units, seen only while the axis turns
   assign zero_mark_pulse = marks_on && motion_cmd.enable && (axis_position[5:0] == 6'h00);
   // Active-low cam; it releases once the cw run has passed it again
   assign ccw_limit_input = (axis_position > cam_pos);
   // Position follows the command; the brake count restarts on every move
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         axis_position <= 32'sh0;
         brake_reg <= 2'h0;
         half_reg <= 1'b0;
      end else begin
         half_reg <= ~half_reg;
         brake_reg <= motion_cmd.enable ? 2'h0 : (axis_standstill ? brake_reg : brake_reg + 2'h1);
         if (step) begin
            axis_position <= motion_cmd.dir_ccw ? axis_position - 32'sh1 : axis_position + 32'sh1;
         end
      end
   end
endmodule // axis_model
`default_nettype wire

/* dv/homing_sequencer_tb_top.sv */
// Self-checking bench for the homing sequencer with a behavioural axis.
// Assumes a 125 MHz core clock and the register port of the sequencer.
`timescale 1ns/100ps
`default_nettype none
module homing_sequencer_tb_top;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic start_homing_request = 1'b0;
   logic cw_limit_input = 1'b1;
   logic slow = 1'b0;
   logic marks_on = 1'b1;
   logic signed [31:0] cam_pos = -32'sh100000;
   logic signed [31:0] axis_position;
   logic axis_standstill, zero_mark_pulse, ccw_limit_input;
   homing_pkg::motion_cmd_type motion_cmd;
   logic homing_done_output, homing_error, homing_busy, cw_limit_stop, ccw_limit_stop;
   int errors = 0;
   int n_checks = 0;
   int seed = 26;
   int offs, n, k;
   logic [31:0] zm_spd, rp_spd, cam_spd, rd;
   logic signed [31:0] zm_at;
   logic zm_seen = 1'b0;
   logic ccw_q = 1'b1;
   always #4 core_clk = ~core_clk;
   homing_sequencer DUT (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .start_homing_request(start_homing_request), .ccw_limit_input(ccw_limit_input),
      .cw_limit_input(cw_limit_input), .zero_mark_pulse(zero_mark_pulse),
      .axis_position(axis_position), .axis_standstill(axis_standstill), .motion_cmd(motion_cmd),
      .homing_done_output(homing_done_output), .homing_error(homing_error),
      .homing_busy(homing_busy), .cw_limit_stop(cw_limit_stop), .ccw_limit_stop(ccw_limit_stop));
   axis_model axis (.core_clk(core_clk), .reset_n(reset_n), .motion_cmd(motion_cmd), .slow(slow),
      .marks_on(marks_on), .cam_pos(cam_pos), .axis_position(axis_position),
      .axis_standstill(axis_standstill), .zero_mark_pulse(zero_mark_pulse),
      .ccw_limit_input(ccw_limit_input));
   // First counted zero mark: zero-mark speed, cam released a cycle ago, axis turning
   always @(posedge core_clk) begin
      ccw_q <= ccw_limit_input;
      if (!start_homing_request) zm_seen <= 1'b0;
      else if (homing_busy === 1'b1 && motion_cmd.enable === 1'b1 && !zm_seen &&
          motion_cmd.speed === zm_spd[25:0] && ccw_q && zero_mark_pulse) begin
         zm_seen <= 1'b1;
         zm_at <= axis_position;
      end
   end
   // ************************************************
   // Checks, bus cycles and expectations
   // ************************************************
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict();
      if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Factory values; status shows idle, unmapped places read zero
   function automatic logic [31:0] rst_val(input logic [3:0] a);
      case (a)
         homing_pkg::MODE_IDX: return {29'h0, homing_pkg::MODE_RST};
         homing_pkg::DIR_IDX: return {31'h0, homing_pkg::DIR_RST};
         homing_pkg::CAM_SPEED_IDX: return {6'h0, homing_pkg::CAM_SPEED_RST};
         homing_pkg::CAM_MAX_IDX: return {1'b0, homing_pkg::CAM_MAX_RST};
         homing_pkg::ZM_SPEED_IDX: return {6'h0, homing_pkg::ZM_SPEED_RST};
         homing_pkg::ZM_MAX_IDX: return {1'b0, homing_pkg::ZM_MAX_RST};
         homing_pkg::RP_SPEED_IDX: return {6'h0, homing_pkg::RP_SPEED_RST};
         homing_pkg::CTRL_IDX: return 32'h0000_0001;
         homing_pkg::STATUS_IDX: return 32'h0000_0004;
         default: return 32'h0000_0000;
      endcase
   endfunction
   function automatic logic hit(input int what);
      case (what)
         0: return homing_done_output === 1'b1;
         1: return homing_error === 1'b1;
         2: return motion_cmd.max_decel === 1'b1;
         3: return motion_cmd.enable === 1'b1;
         default: return zm_seen && motion_cmd.enable === 1'b0;
      endcase
   endfunction
   // Bounded wait; the count of cycles taken comes back in n
   task automatic wait_hit(input int what, input int lim);
      n = 0;
      while (!hit(what) && n < lim) begin
         @(posedge core_clk);
         #1 n++;
      end
      check("wait for event", 32'h1, {31'h0, hit(what)});
   endtask
   task automatic start_run();
      @(posedge core_clk);
      start_homing_request <= 1'b1;
      @(posedge core_clk);
      #1 check("busy after start", 32'h1, {31'h0, homing_busy});
   endtask
   task automatic stop_run(input logic decel);
      @(posedge core_clk);
      start_homing_request <= 1'b0;
      @(posedge core_clk);
      #1 check("outputs after stop", {28'h0, decel, 3'h0},
         {28'h0, motion_cmd.max_decel, homing_done_output, homing_busy, motion_cmd.enable});
   endtask
   // Full run in mode 2 or 3 with random speeds, offset and axis pace
   task automatic home(input logic [2:0] mode, input logic dir, input logic done_en);
      zm_spd = 32'h1 + ($random(seed) & 32'h3FF);
      rp_spd = zm_spd + 32'h1 + ($random(seed) & 32'hFF);
      cam_spd = rp_spd + 32'h1 + ($random(seed) & 32'hFFFF);
      offs = $random(seed) % 51;
      slow <= $random(seed);
      cam_pos <= (mode == 3'h3) ? axis_position - 32'sd40 : axis_position - 32'sd100000;
      reg_write(homing_pkg::MODE_IDX, {29'h0, mode});
      reg_write(homing_pkg::DIR_IDX, {31'h0, dir});
      reg_write(homing_pkg::CTRL_IDX, {31'h0, done_en});
      reg_write(homing_pkg::OFFSET_IDX, offs);
      reg_write(homing_pkg::ZM_SPEED_IDX, zm_spd);
      reg_write(homing_pkg::RP_SPEED_IDX, rp_spd);
      reg_write(homing_pkg::CAM_SPEED_IDX, cam_spd);
      reg_write(homing_pkg::CAM_MAX_IDX, 32'd500);
      reg_write(homing_pkg::ZM_MAX_IDX, 32'd500);
      cw_limit_input <= 1'b0;
      start_run();
      check("first phase", {mode == 3'h3 ? cam_spd[25:0] : zm_spd[25:0], 1'b1, (mode == 3'h3) | dir},
         {motion_cmd.speed, motion_cmd.enable, motion_cmd.dir_ccw});
      check("limits ignored", 32'h0, {30'h0, cw_limit_stop, ccw_limit_stop});
      if (mode == 3'h3) begin
         wait_hit(2, 200);
         check("cam stop", 32'h0, {31'h0, motion_cmd.enable | ccw_limit_input});
         wait_hit(3, 10);
         check("reversal", {zm_spd[25:0], 1'b0}, {motion_cmd.speed, motion_cmd.dir_ccw});
      end
      wait_hit(done_en ? 0 : 4, 1000);
      check("at reference", 32'h1, {31'h0, $unsigned(axis_position - zm_at - offs + 2) <= 4});
      check("done follows enable", {30'h0, done_en, 1'b0},
         {30'h0, homing_done_output, motion_cmd.enable});
      repeat (5) @(posedge core_clk);
      #1 check("done holds", {31'h0, done_en}, {31'h0, homing_done_output});
      reg_read(homing_pkg::STATUS_IDX, rd);
      check("status at end", {23'h0, 7'h20, 1'b0, done_en}, rd);
      stop_run(1'b0);
      cw_limit_input <= $random(seed);
      @(posedge core_clk);
      @(posedge core_clk);
      #1 check("limits restored", {31'h0, !cw_limit_input}, {31'h0, cw_limit_stop});
   endtask
   // Overrun: no zero mark or a far cam, so the search distance runs out
   task automatic overrun(input logic [2:0] mode, input logic [3:0] idx, input int lim);
      marks_on <= 1'b0;
      slow <= 1'b0;
      cam_pos <= axis_position - 32'sd100000;
      reg_write(homing_pkg::MODE_IDX, {29'h0, mode});
      reg_write(idx, lim);
      start_run();
      wait_hit(1, 60);
      check("overrun span", 32'h1, {31'h0, n >= lim && n <= lim + 4});
      reg_read(homing_pkg::STATUS_IDX, rd);
      check("fault status", {23'h0, 7'h40, 2'h2}, rd);
      stop_run(1'b0);
      marks_on <= 1'b1;
   endtask
   initial begin
      #400000;
      errors++;
      print_verdict();
   end
   initial begin
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      for (k = 0; k < 12; k++) begin
         reg_read(k[3:0], rd);
         check("reset value", rst_val(k[3:0]), rd);
      end
      for (k = 2; k < 4; k++) begin
         offs = $random(seed);
         reg_write(k[3:0], offs);
         reg_read(k[3:0], rd);
         check("signed word", offs, rd);
      end
      reg_write(4'hB, 32'hFFFF_FFFF);
      reg_read(4'hB, rd);
      check("unmapped", 32'h0, rd);
      for (k = 0; k < 8; k++) home(k[0] ? 3'h3 : 3'h2, k[0] | $random(seed), k != 2);
      marks_on <= 1'b0;
      reg_write(homing_pkg::MODE_IDX, 32'h2);
      start_run();
      repeat (3) @(posedge core_clk);
      stop_run(1'b1);
      overrun(3'h2, homing_pkg::ZM_MAX_IDX, 10);
      reg_write(homing_pkg::DIR_IDX, 32'h1);
      overrun(3'h3, homing_pkg::CAM_MAX_IDX, 20);
      for (k = 0; k < 5; k = k + ((k == 1) ? 3 : 1)) begin
         reg_write(homing_pkg::MODE_IDX, k);
         start_run();
         wait_hit(1, 3);
         check("no motion", 32'h0, {31'h0, motion_cmd.enable});
         stop_run(1'b0);
      end
      home(3'h2, 1'b0, 1'b1);
      start_run();
      @(posedge core_clk);
      reset_n <= 1'b0;
      start_homing_request <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 check("mid-run reset", 32'h0, {30'h0, homing_busy, motion_cmd.enable});
      @(posedge core_clk);
      reset_n <= 1'b1;
      reg_read(homing_pkg::DIR_IDX, rd);
      check("direction after reset", 32'h0, rd);
      print_verdict();
   end
endmodule // homing_sequencer_tb_top
`default_nettype wire
